// [rtl/fdx_edge.sv]
`timescale 1ns/10ps
`default_nettype none
module fdx_edge (
    input wire logic pclk,
    input wire logic presetn,
    fdx_edge_if.det eif
);
    logic [1:0] prev_reg;

    // idle-high reset keeps the first sample from faking a falling edge
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prev_reg <= 2'h3;
        end else begin
            prev_reg <= eif.pin_level;
        end
    end

    // even events watch the bit-2 pin, odd ones the bit-6 pin
    for (genvar i = 0; i < fdx_pkg::EVT_COUNT; i++) begin : g_evt
        assign eif.evt[i] = (prev_reg[i % 2] & ~eif.pin_level[i % 2])
            | (eif.edge_mode[i] & ~prev_reg[i % 2] & eif.pin_level[i % 2]); // [R08] [R09] [R10] [R11]
    end
endmodule
`default_nettype wire

// [rtl/fdx_edge_if.sv]
`timescale 1ns/10ps
`default_nettype none
interface fdx_edge_if;
    logic [1:0] pin_level;
    logic [3:0] edge_mode;
    logic [3:0] evt;
    modport top (output pin_level, output edge_mode, input evt);
    modport det (input pin_level, input edge_mode, output evt);
endinterface
`default_nettype wire

// [rtl/fdx_pkg.sv]
`default_nettype none
package fdx_pkg;
    // register indices; byte address is four times the index
    localparam logic [9:0] IDX_FORCE_CHG = 10'h01E;
    localparam logic [9:0] IDX_RATE_SHADOW = 10'h01F;
    localparam logic [9:0] IDX_FIFO_SHADOW = 10'h020;
    localparam logic [9:0] IDX_EDGE_SEL = 10'h021;
    localparam logic [9:0] IDX_EVT_STATUS = 10'h030;
    localparam logic [9:0] IDX_EVT_MASK = 10'h031;

    localparam logic [1:0] FORCE_RST = 2'h3;
    localparam logic [7:0] RATE_RST = 8'h02;
    localparam logic [7:0] FIFO_RST = 8'h00;
    localparam logic [3:0] EDGE_RST = 4'h0;
    localparam logic [3:0] EVT_STATUS_RST = 4'h0;
    localparam logic [3:0] EVT_MASK_RST = 4'h0;

    // implemented bits of each shadow; the rest read as zero
    localparam logic [7:0] RATE_MASK = 8'hDF;
    localparam logic [7:0] FIFO_MASK = 8'hCF;

    localparam int FORCE_DS0_BIT = 0;
    localparam int FORCE_DS1_BIT = 1;

    // event bits share positions with the edge-select bits
    localparam int EVT_SMI_P12 = 0;
    localparam int EVT_SMI_P16 = 1;
    localparam int EVT_PME_P12 = 2;
    localparam int EVT_PME_P16 = 3;
    localparam int EVT_COUNT = 4;

    localparam int PIN_COUNT = 6;
    localparam logic [5:0] PIN_IDLE = 6'h3F;
    localparam int PIN_STEP = 0;
    localparam int PIN_DS0 = 1;
    localparam int PIN_DS1 = 2;
    localparam int PIN_DSKCHG = 3;
    localparam int PIN_KBD2 = 4;
    localparam int PIN_KBD6 = 5;
endpackage
`default_nettype wire

// [rtl/fdx_regs.sv]
// Notes on behaviour
// [R01] software writing 1 sets a disk-change override bit; writing 0 never clears it
// [R02] drive-1 override clears while step and drive-select-1 are both asserted
// [R03] drive-0 override clears while step and drive-select-0 are both asserted
// [R04] disk-changed status = selected drive with override, or the drive's own input
// [R05] bits 7:2 of the override register always read zero
// [R06] rate shadow: rate 1:0, write_field_a 4:2, power-down 6, soft reset 7
// [R07] fifo shadow: enable 0, rx reset 1, tx reset 2, dma 3, trigger 7:6
// [R08] pin 1.2 smi status: falling edge only, or both edges when selected
// [R09] pin 1.6 smi status: falling edge only, or both edges when selected
// [R10] pin 1.2 wake status: falling edge only, or both edges when selected
// [R11] pin 1.6 wake status: falling edge only, or both edges when selected
// [R12] shadows capture last control write; bus writes to shadows are ignored
//
// Design decision made here: the APB interface to the registers.
`timescale 1ns/10ps
`default_nettype none
module fdx_regs (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic step_pulse_n,
    input wire logic drive_select0_n,
    input wire logic drive_select1_n,
    input wire logic disk_changed_in_n,
    input wire logic kbd_port1_bit2,
    input wire logic kbd_port1_bit6,
    input wire logic rate_wr_strobe,
    input wire logic [7:0] rate_wr_data,
    input wire logic fifo_ctl_wr_strobe,
    input wire logic [7:0] fifo_ctl_wr_data,
    output logic disk_changed_status,
    output logic event_irq
);
    localparam int PIN_W = fdx_pkg::PIN_COUNT;
    logic [PIN_W-1:0] pin_raw;
    logic [PIN_W-1:0] pin_s;
    logic [1:0] force_reg;
    logic [1:0] force_next;
    logic [1:0] force_clr;
    logic [1:0] force_set;
    logic [7:0] rate_shadow_reg;
    logic [7:0] fifo_shadow_reg;
    logic [3:0] edge_sel_reg;
    logic [3:0] evt_status_reg;
    logic [3:0] evt_status_next;
    logic [3:0] evt_mask_reg;
    logic [31:0] rd_next;
    logic hit_any;
    logic wr_en;
    logic setup_phase;
    logic [9:0] acc_idx;

    fdx_edge_if eif ();

    // decode of a word-aligned register index
    function automatic logic reg_hit(input logic [11:0] addr, input logic [9:0] idx);
        reg_hit = (addr[1:0] == 2'h0) && (addr[11:2] == idx);
    endfunction

    assign pin_raw[fdx_pkg::PIN_STEP] = step_pulse_n;
    assign pin_raw[fdx_pkg::PIN_DS0] = drive_select0_n;
    assign pin_raw[fdx_pkg::PIN_DS1] = drive_select1_n;
    assign pin_raw[fdx_pkg::PIN_DSKCHG] = disk_changed_in_n;
    assign pin_raw[fdx_pkg::PIN_KBD2] = kbd_port1_bit2;
    assign pin_raw[fdx_pkg::PIN_KBD6] = kbd_port1_bit6;

    fdx_sync #(
        .W(PIN_W),
        .INIT(fdx_pkg::PIN_IDLE)
    ) u_sync (
        .pclk(pclk),
        .presetn(presetn),
        .d(pin_raw),
        .q(pin_s)
    );

    assign eif.pin_level = {pin_s[fdx_pkg::PIN_KBD6], pin_s[fdx_pkg::PIN_KBD2]};
    assign eif.edge_mode = edge_sel_reg;

    fdx_edge u_edge (
        .pclk(pclk),
        .presetn(presetn),
        .eif(eif)
    );

    // zero-wait slave: pready rises in the access cycle
    assign setup_phase = psel && !penable;
    assign wr_en = psel && penable && pwrite && pready;
    assign acc_idx = paddr[11:2];

    always_comb begin
        hit_any = reg_hit(paddr, fdx_pkg::IDX_FORCE_CHG)
            || reg_hit(paddr, fdx_pkg::IDX_RATE_SHADOW)
            || reg_hit(paddr, fdx_pkg::IDX_FIFO_SHADOW)
            || reg_hit(paddr, fdx_pkg::IDX_EDGE_SEL)
            || reg_hit(paddr, fdx_pkg::IDX_EVT_STATUS)
            || reg_hit(paddr, fdx_pkg::IDX_EVT_MASK);
    end

    always_comb begin
        rd_next = 32'h0000_0000;
        if (reg_hit(paddr, fdx_pkg::IDX_FORCE_CHG)) begin
            rd_next = {30'h0000_0000, force_reg}; // [R05]
        end else if (reg_hit(paddr, fdx_pkg::IDX_RATE_SHADOW)) begin
            rd_next = {24'h00_0000, rate_shadow_reg};
        end else if (reg_hit(paddr, fdx_pkg::IDX_FIFO_SHADOW)) begin
            rd_next = {24'h00_0000, fifo_shadow_reg};
        end else if (reg_hit(paddr, fdx_pkg::IDX_EDGE_SEL)) begin
            rd_next = {28'h000_0000, edge_sel_reg};
        end else if (reg_hit(paddr, fdx_pkg::IDX_EVT_STATUS)) begin
            rd_next = {28'h000_0000, evt_status_reg};
        end else if (reg_hit(paddr, fdx_pkg::IDX_EVT_MASK)) begin
            rd_next = {28'h000_0000, evt_mask_reg};
        end
    end

    // read data is latched at setup; a status change during the access shows next read
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end else begin
            pready <= setup_phase;
            pslverr <= setup_phase && !hit_any;
            if (setup_phase && !pwrite) begin
                prdata <= rd_next;
            end
        end
    end

    // hardware clear and software set; a set in the same cycle wins
    always_comb begin
        force_clr[fdx_pkg::FORCE_DS0_BIT] = !pin_s[fdx_pkg::PIN_STEP]
            && !pin_s[fdx_pkg::PIN_DS0]; // [R03]
        force_clr[fdx_pkg::FORCE_DS1_BIT] = !pin_s[fdx_pkg::PIN_STEP]
            && !pin_s[fdx_pkg::PIN_DS1]; // [R02]
        force_set = 2'h0;
        if (wr_en && reg_hit(paddr, fdx_pkg::IDX_FORCE_CHG)) begin
            force_set = pwdata[1:0]; // [R01]
        end
        force_next = (force_reg & ~force_clr) | force_set; // [R01]
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            force_reg <= fdx_pkg::FORCE_RST;
        end else begin
            force_reg <= force_next;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            disk_changed_status <= 1'b0;
        end else begin
            disk_changed_status <= (!pin_s[fdx_pkg::PIN_DS0] && force_reg[0])
                || (!pin_s[fdx_pkg::PIN_DS1] && force_reg[1])
                || !pin_s[fdx_pkg::PIN_DSKCHG]; // [R04]
        end
    end

    // shadows follow only the controllers' own write strobes
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rate_shadow_reg <= fdx_pkg::RATE_RST;
        end else if (rate_wr_strobe) begin
            rate_shadow_reg <= rate_wr_data & fdx_pkg::RATE_MASK; // [R06] [R12]
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fifo_shadow_reg <= fdx_pkg::FIFO_RST;
        end else if (fifo_ctl_wr_strobe) begin
            fifo_shadow_reg <= fifo_ctl_wr_data & fdx_pkg::FIFO_MASK; // [R07] [R12]
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            edge_sel_reg <= fdx_pkg::EDGE_RST;
        end else if (wr_en && reg_hit(paddr, fdx_pkg::IDX_EDGE_SEL)) begin
            edge_sel_reg <= pwdata[3:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            evt_mask_reg <= fdx_pkg::EVT_MASK_RST;
        end else if (wr_en && reg_hit(paddr, fdx_pkg::IDX_EVT_MASK)) begin
            evt_mask_reg <= pwdata[3:0];
        end
    end

    // write-one-to-clear; a fresh edge outranks the clear
    always_comb begin
        evt_status_next = evt_status_reg;
        if (wr_en && reg_hit(paddr, fdx_pkg::IDX_EVT_STATUS)) begin
            evt_status_next = evt_status_reg & ~pwdata[3:0];
        end
        evt_status_next = evt_status_next | eif.evt; // [R08] [R09] [R10] [R11]
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            evt_status_reg <= fdx_pkg::EVT_STATUS_RST;
        end else begin
            evt_status_reg <= evt_status_next;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            event_irq <= 1'b0;
        end else begin
            event_irq <= |(evt_status_next & evt_mask_reg);
        end
    end

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    sequence s_wr(logic [9:0] idx);
        psel && penable && pwrite && pready && (paddr[1:0] == 2'h0) && (acc_idx == idx);
    endsequence

    sequence s_rd_setup(logic [9:0] idx);
        psel && !penable && !pwrite && (paddr[1:0] == 2'h0) && (acc_idx == idx);
    endsequence

    sequence s_rd_access;
        psel && penable && !pwrite && pready;
    endsequence

    force_set_a: assert property (s_wr(fdx_pkg::IDX_FORCE_CHG) ##0 pwdata[0] // [R01]
        |=> force_reg[0]) else $error("override 0 not set by write");

    force_keep_a: assert property (s_wr(fdx_pkg::IDX_FORCE_CHG) ##0 !pwdata[1] // [R01]
        && force_reg[1] && !force_clr[1] |=> force_reg[1])
        else $error("software cleared override 1");

    // the write set outranks a clear from the drive pins in the same cycle
    force_win_a: assert property (s_wr(fdx_pkg::IDX_FORCE_CHG) ##0 pwdata[1] // [R01]
        |=> force_reg[1]) else $error("override 1 not set by write");

    force_clr1_a: assert property (!pin_s[fdx_pkg::PIN_STEP] && !pin_s[fdx_pkg::PIN_DS1] // [R02]
        && !force_set[1] |=> !force_reg[1]) else $error("override 1 not cleared");

    force_clr0_a: assert property (!pin_s[fdx_pkg::PIN_STEP] && !pin_s[fdx_pkg::PIN_DS0] // [R03]
        && !force_set[0] |=> !force_reg[0]) else $error("override 0 not cleared");

    dsk_status_a: assert property (##1 disk_changed_status // [R04]
        == (($past(!pin_s[fdx_pkg::PIN_DS0]) && $past(force_reg[0]))
        || ($past(!pin_s[fdx_pkg::PIN_DS1]) && $past(force_reg[1]))
        || $past(!pin_s[fdx_pkg::PIN_DSKCHG])))
        else $error("disk changed status wrong");

    force_rsvd_a: assert property (s_rd_setup(fdx_pkg::IDX_FORCE_CHG) // [R05]
        |=> pready && (prdata[31:2] == 30'h0000_0000))
        else $error("override reserved bits nonzero");

    rate_layout_a: assert property (rate_wr_strobe |=> (rate_shadow_reg // [R06]
        == ($past(rate_wr_data) & fdx_pkg::RATE_MASK)) && !rate_shadow_reg[5])
        else $error("rate shadow layout wrong");

    rate_read_a: assert property (s_rd_setup(fdx_pkg::IDX_RATE_SHADOW) ##1 s_rd_access // [R06]
        |-> prdata == {24'h00_0000, $past(rate_shadow_reg)})
        else $error("rate shadow read wrong");

    fifo_layout_a: assert property (fifo_ctl_wr_strobe |=> (fifo_shadow_reg[3:0] // [R07]
        == $past(fifo_ctl_wr_data[3:0])) && (fifo_shadow_reg[7:6]
        == $past(fifo_ctl_wr_data[7:6])) && (fifo_shadow_reg[5:4] == 2'h0))
        else $error("fifo shadow layout wrong");

    fifo_read_a: assert property (s_rd_setup(fdx_pkg::IDX_FIFO_SHADOW) ##1 s_rd_access // [R07]
        |-> prdata == {24'h00_0000, $past(fifo_shadow_reg)})
        else $error("fifo shadow read wrong");

    edge_wr_a: assert property (s_wr(fdx_pkg::IDX_EDGE_SEL)
        |=> edge_sel_reg == $past(pwdata[3:0])) else $error("edge select not written");

    edge_read_a: assert property (s_rd_setup(fdx_pkg::IDX_EDGE_SEL) ##1 s_rd_access
        |-> prdata == {28'h000_0000, $past(edge_sel_reg)})
        else $error("edge select read wrong");

    smi12_edge_a: assert property ($fell(eif.pin_level[0]) // [R08]
        || (edge_sel_reg[0] && $rose(eif.pin_level[0]))
        |=> evt_status_reg[fdx_pkg::EVT_SMI_P12]) else $error("p12 smi edge missed");

    smi12_rise_a: assert property (!edge_sel_reg[0] && $rose(eif.pin_level[0]) // [R08]
        && !evt_status_reg[0] |=> !evt_status_reg[fdx_pkg::EVT_SMI_P12])
        else $error("p12 smi set on rising edge");

    smi16_edge_a: assert property ($fell(eif.pin_level[1]) // [R09]
        || (edge_sel_reg[1] && $rose(eif.pin_level[1]))
        |=> evt_status_reg[fdx_pkg::EVT_SMI_P16]) else $error("p16 smi edge missed");

    smi16_rise_a: assert property (!edge_sel_reg[1] && $rose(eif.pin_level[1]) // [R09]
        && !evt_status_reg[1] |=> !evt_status_reg[fdx_pkg::EVT_SMI_P16])
        else $error("p16 smi set on rising edge");

    pme12_edge_a: assert property ($fell(eif.pin_level[0]) // [R10]
        || (edge_sel_reg[2] && $rose(eif.pin_level[0]))
        |=> evt_status_reg[fdx_pkg::EVT_PME_P12]) else $error("p12 wake edge missed");

    pme12_rise_a: assert property (!edge_sel_reg[2] && $rose(eif.pin_level[0]) // [R10]
        && !evt_status_reg[2] |=> !evt_status_reg[fdx_pkg::EVT_PME_P12])
        else $error("p12 wake set on rising edge");

    pme16_edge_a: assert property ($fell(eif.pin_level[1]) // [R11]
        || (edge_sel_reg[3] && $rose(eif.pin_level[1]))
        |=> evt_status_reg[fdx_pkg::EVT_PME_P16]) else $error("p16 wake edge missed");

    pme16_rise_a: assert property (!edge_sel_reg[3] && $rose(eif.pin_level[1]) // [R11]
        && !evt_status_reg[3] |=> !evt_status_reg[fdx_pkg::EVT_PME_P16])
        else $error("p16 wake set on rising edge");

    shadow_ro_a: assert property ((s_wr(fdx_pkg::IDX_RATE_SHADOW) // [R12]
        or s_wr(fdx_pkg::IDX_FIFO_SHADOW)) ##0 !rate_wr_strobe && !fifo_ctl_wr_strobe
        |=> $stable(rate_shadow_reg) && $stable(fifo_shadow_reg))
        else $error("bus write altered a shadow");

    mask_wr_a: assert property (s_wr(fdx_pkg::IDX_EVT_MASK)
        |=> evt_mask_reg == $past(pwdata[3:0])) else $error("event mask not written");

    evt_w1c_a: assert property (s_wr(fdx_pkg::IDX_EVT_STATUS) ##0 (eif.evt == 4'h0)
        |=> (evt_status_reg & $past(pwdata[3:0])) == 4'h0)
        else $error("event status not cleared by write");

    pready_pulse_a: assert property (pready |=> !pready)
        else $error("pready held past one cycle");

    irq_level_a: assert property (##1 event_irq
        == |($past(evt_status_next) & $past(evt_mask_reg)))
        else $error("interrupt level wrong");

    unmapped_err_a: assert property (psel && !penable && !hit_any |=> pslverr && pready)
        else $error("unmapped access not flagged");
endmodule
`default_nettype wire

// [rtl/fdx_sync.sv]
`timescale 1ns/10ps
`default_nettype none
module fdx_sync #(
    parameter int W = 6,
    parameter logic [W-1:0] INIT = '1
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta_reg;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta_reg <= INIT;
            q <= INIT;
        end else begin
            meta_reg <= d;
            q <= meta_reg;
        end
    end
endmodule
`default_nettype wire

// [tb/fdd_uart_shadow_edge_regs_tb.sv]
`timescale 1ns/10ps
`default_nettype none
module fdd_uart_shadow_edge_regs_tb;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [5:0] pins;
    logic rs, fs, dcs, irq;
    logic [7:0] rd_d, fd_d;
    logic [32:0] exp_q[$];
    logic [32:0] e;
    logic [31:0] rnd = 32'hC2D7;
    logic [3:0] modes[4] = '{4'h0, 4'hF, 4'h5, 4'hA};
    int n_fail = 0;
    int checked = 0;
    int cycles = 0;

    always #4 pclk = ~pclk;

    fdx_regs i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .step_pulse_n(pins[0]), .drive_select0_n(pins[1]),
        .drive_select1_n(pins[2]), .disk_changed_in_n(pins[3]), .kbd_port1_bit2(pins[4]),
        .kbd_port1_bit6(pins[5]), .rate_wr_strobe(rs), .rate_wr_data(rd_d),
        .fifo_ctl_wr_strobe(fs), .fifo_ctl_wr_data(fd_d), .disk_changed_status(dcs),
        .event_irq(irq));

    fdx_far_model i_far (.pclk(pclk), .pins(pins), .rate_wr_strobe(rs), .rate_wr_data(rd_d),
        .fifo_ctl_wr_strobe(fs), .fifo_ctl_wr_data(fd_d));

    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction

    task automatic chk(input string nm, input logic [32:0] seen, input logic [32:0] exp);
        checked++;
        if (seen !== exp) begin
            n_fail++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic end_sim();
        $display("comparisons %0d mismatches %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic apb(input logic w, input logic [9:0] idx, input logic [31:0] d,
                       input logic [32:0] ex);
        exp_q.push_back(ex);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= {idx, 2'b00};
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [9:0] idx, input logic [31:0] d);
        apb(1'b1, idx, d, 33'h0);
    endtask

    task automatic rd(input logic [9:0] idx, input logic [31:0] ex);
        apb(1'b0, idx, 32'h0, {1'b0, ex});
    endtask

    task automatic wt(input int n);
        repeat (n) @(posedge pclk);
    endtask

    // the transfer answer is judged against the oldest note
    always @(posedge pclk) begin
        if (psel && penable && pready === 1'b1) begin
            if (exp_q.size() == 0) begin
                chk("unexpected transfer", 33'h0, 33'h1);
            end else begin
                e = exp_q.pop_front();
                chk("apb answer", {pslverr, pwrite ? 32'h0 : prdata}, e);
            end
        end
    end

    always @(posedge pclk) begin
        cycles++;
        if (cycles == 20000) begin
            n_fail++;
            end_sim();
        end
    end

    initial begin
        wt(10);
        presetn <= 1'b1;
        rd(fdx_pkg::IDX_FORCE_CHG, 32'h3);
        rd(fdx_pkg::IDX_RATE_SHADOW, 32'h2);
        rd(fdx_pkg::IDX_FIFO_SHADOW, 32'h0);
        rd(fdx_pkg::IDX_EDGE_SEL, 32'h0);
        rd(fdx_pkg::IDX_EVT_STATUS, 32'h0);
        rd(fdx_pkg::IDX_EVT_MASK, 32'h0);
        apb(1'b0, 10'h3FF, 32'h0, {1'b1, 32'h0});
        $display("test reset_values done");
        wr(fdx_pkg::IDX_FORCE_CHG, 32'hFFFF_FFFC);
        rd(fdx_pkg::IDX_FORCE_CHG, 32'h3);
        i_far.set_pins(6'h3A);
        wt(4);
        i_far.set_pins(6'h3F);
        rd(fdx_pkg::IDX_FORCE_CHG, 32'h1);
        i_far.set_pins(6'h3C);
        wt(4);
        i_far.set_pins(6'h3D);
        rd(fdx_pkg::IDX_FORCE_CHG, 32'h0);
        wt(4);
        chk("disk_changed_status idle", {32'h0, dcs}, 33'h0);
        wr(fdx_pkg::IDX_FORCE_CHG, 32'h1);
        rd(fdx_pkg::IDX_FORCE_CHG, 32'h1);
        wt(3);
        chk("disk_changed_status forced", {32'h0, dcs}, 33'h1);
        i_far.set_pins(6'h3F);
        wt(4);
        chk("disk_changed_status deselected", {32'h0, dcs}, 33'h0);
        i_far.set_pins(6'h37);
        wt(4);
        chk("disk_changed_status pin", {32'h0, dcs}, 33'h1);
        // random drive pins with step idle; both overrides armed, so any low select shows
        wr(fdx_pkg::IDX_FORCE_CHG, {rnd[31:2], 2'h3});
        rd(fdx_pkg::IDX_FORCE_CHG, 32'h3);
        for (int k = 0; k < 8; k++) begin
            rnd = lfsr(rnd);
            i_far.set_pins({rnd[5:1], 1'b1});
            wt(4);
            chk("disk_changed_status random", {32'h0, dcs}, {32'h0, !(rnd[1] && rnd[2] && rnd[3])});
        end
        i_far.set_pins(6'h3F);
        $display("test disk_change done");
        for (int k = 0; k < 4; k++) begin
            rnd = lfsr(rnd);
            i_far.wr_rate(rnd[7:0]);
            i_far.wr_fifo(rnd[15:8]);
            wr(fdx_pkg::IDX_RATE_SHADOW, 32'hFF);
            wr(fdx_pkg::IDX_FIFO_SHADOW, 32'hFF);
            rd(fdx_pkg::IDX_RATE_SHADOW, {24'h0, rnd[7:0] & 8'hDF});
            rd(fdx_pkg::IDX_FIFO_SHADOW, {24'h0, rnd[15:8] & 8'hCF});
        end
        $display("test shadows done");
        foreach (modes[m]) begin
            wr(fdx_pkg::IDX_EDGE_SEL, {28'h0, modes[m]});
            rd(fdx_pkg::IDX_EDGE_SEL, {28'h0, modes[m]});
            i_far.set_pins(6'h0F);
            wt(4);
            rd(fdx_pkg::IDX_EVT_STATUS, 32'hF);
            chk("irq masked", {32'h0, irq}, 33'h0);
            wr(fdx_pkg::IDX_EVT_STATUS, 32'hF);
            rd(fdx_pkg::IDX_EVT_STATUS, 32'h0);
            i_far.set_pins(6'h3F);
            wt(4);
            rd(fdx_pkg::IDX_EVT_STATUS, {28'h0, modes[m]});
            wr(fdx_pkg::IDX_EVT_MASK, 32'hF);
            wt(2);
            chk("irq unmasked", {32'h0, irq}, {32'h0, modes[m] != 4'h0});
            wr(fdx_pkg::IDX_EVT_STATUS, 32'hF);
            wt(2);
            chk("irq cleared", {32'h0, irq}, 33'h0);
            wr(fdx_pkg::IDX_EVT_MASK, 32'h0);
        end
        $display("test edge_select done");
        wt(4);
        end_sim();
    end
endmodule
`default_nettype wire

// [tb/fdx_far_model.sv]
`timescale 1ns/10ps
`default_nettype none
module fdx_far_model (
    input wire logic pclk,
    output logic [5:0] pins,
    output logic rate_wr_strobe,
    output logic [7:0] rate_wr_data,
    output logic fifo_ctl_wr_strobe,
    output logic [7:0] fifo_ctl_wr_data
);
    initial begin
        pins = fdx_pkg::PIN_IDLE;
        rate_wr_strobe = 1'b0;
        rate_wr_data = 8'h00;
        fifo_ctl_wr_strobe = 1'b0;
        fifo_ctl_wr_data = 8'h00;
    end
    // pins move just after an edge; the sync flops take the rest
    task automatic set_pins(input logic [5:0] v);
        @(posedge pclk);
        pins <= v;
    endtask
    // data is inverted once the strobe drops, so no stale value looks valid
    task automatic wr_rate(input logic [7:0] d);
        @(posedge pclk);
        rate_wr_strobe <= 1'b1;
        rate_wr_data <= d;
        @(posedge pclk);
        rate_wr_strobe <= 1'b0;
        rate_wr_data <= ~d;
    endtask
    task automatic wr_fifo(input logic [7:0] d);
        @(posedge pclk);
        fifo_ctl_wr_strobe <= 1'b1;
        fifo_ctl_wr_data <= d;
        @(posedge pclk);
        fifo_ctl_wr_strobe <= 1'b0;
        fifo_ctl_wr_data <= ~d;
    endtask
endmodule
`default_nettype wire
